// [hdl/bbx_exec_map.vh]
// constants for the branch, bit and flag execution unit
`ifndef BBX_EXEC_MAP_VH
`define BBX_EXEC_MAP_VH
// status flag bit positions
`define BBX_FLAG_C        3'd0
`define BBX_FLAG_Z        3'd1
`define BBX_FLAG_N        3'd2
`define BBX_FLAG_V        3'd3
`define BBX_FLAG_S        3'd4
`define BBX_FLAG_H        3'd5
`define BBX_FLAG_T        3'd6
`define BBX_FLAG_I        3'd7
`define BBX_FLAGS_RESET   8'h00
// operation codes on op_code
`define BBX_OP_NOP        5'h00
`define BBX_OP_BR_ZERO0   5'h01
`define BBX_OP_BR_C1      5'h02
`define BBX_OP_BR_C0      5'h03
`define BBX_OP_BR_UGE     5'h04
`define BBX_OP_BR_ULT     5'h05
`define BBX_OP_BR_N1      5'h06
`define BBX_OP_BR_N0      5'h07
`define BBX_OP_BR_SGE     5'h08
`define BBX_OP_BR_SLT     5'h09
`define BBX_OP_BR_H1      5'h0A
`define BBX_OP_BR_H0      5'h0B
`define BBX_OP_BR_T1      5'h0C
`define BBX_OP_BR_T0      5'h0D
`define BBX_OP_BR_V1      5'h0E
`define BBX_OP_BR_V0      5'h0F
`define BBX_OP_BR_I1      5'h10
`define BBX_OP_BR_I0      5'h11
`define BBX_OP_IO_SET     5'h12
`define BBX_OP_IO_CLR     5'h13
`define BBX_OP_LSL        5'h14
`define BBX_OP_LSR        5'h15
`define BBX_OP_ROL        5'h16
`define BBX_OP_ROR        5'h17
`define BBX_OP_ASR        5'h18
`define BBX_OP_SWAP       5'h19
`define BBX_OP_FLAG_SET   5'h1A
`define BBX_OP_FLAG_CLR   5'h1B
`define BBX_OP_BST        5'h1C
`define BBX_OP_BLD        5'h1D
// misc
`define BBX_PC_STEP       16'h0001
`define BBX_ZERO8         8'h00
`endif

// [hdl/bbx_exec_unit.v]
// execution unit for flag branches, I/O bit ops, shifts, bit transfer and flag ops
// How it works
// - not-zero branch: pc <= pc + offset + 1 when Z clear; 1 or 2 cycles
// - carry-clear and unsigned-ge branches taken while C is zero
// - carry-set and unsigned-lt branches taken while C is one
// - negative branch on N one, nonnegative on N zero; no flag changes
// - signed-ge branch taken when N xor V is zero
// - signed-lt branch taken when N xor V is one
// - half-carry branches taken on H one or H zero
// - transfer branches taken on T one or T zero, same target and timing
// - overflow branches taken on V one or V zero
// - interrupt branches taken on I one or I zero
// - I/O bit force to one or zero, two cycles, flags untouched
// - logical shifts insert zero, update Z C N V, one cycle
// - rotates take old C in, shifted-out bit to C, update Z C N V
// - arithmetic right shift moves bits 7..1 down, update Z C N V
// - nibble swap in one cycle, no flag changes
// - bit store copies register bit into T only
// - bit load copies T into register bit, no flag changes
// - flag set and clear by index change only the named flag
// - interrupt enable set and clear ops touch only I
// - S flag set and cleared directly by single-cycle ops
`include "bbx_exec_map.vh"
`default_nettype none
module bbx_exec_unit #(
	parameter PC_W = 16
) (
	input  wire            mclk,
	input  wire            sys_rst,
	input  wire            op_valid,
	input  wire [4:0]      op_code,
	input  wire [2:0]      op_bit,
	input  wire [11:0]     op_offset,
	input  wire [PC_W-1:0] pc_in,
	input  wire [7:0]      reg_rdata,
	input  wire [5:0]      io_addr,
	input  wire [7:0]      io_rdata,
	output reg             busy,
	output reg             pc_load,
	output reg  [PC_W-1:0] pc_target,
	output reg             reg_we,
	output reg  [7:0]      reg_wdata,
	output reg             io_re,
	output reg  [5:0]      io_raddr,
	output reg             io_we,
	output reg  [5:0]      io_waddr,
	output reg  [7:0]      io_wdata,
	output reg  [7:0]      status_flags
);
	// flag result of a shift: Z C N V, S follows N xor V
	function [7:0] shift_flags;
		input [7:0] f;
		input [7:0] r;
		input       c;
		reg   [7:0] t;
		begin
			t = f;
			t[`BBX_FLAG_C] = c;
			t[`BBX_FLAG_Z] = (r == `BBX_ZERO8);
			t[`BBX_FLAG_N] = r[7];
			t[`BBX_FLAG_V] = r[7] ^ c;
			t[`BBX_FLAG_S] = r[7] ^ r[7] ^ c;
			shift_flags = t;
		end
	endfunction

	reg            cond;
	reg            is_branch;
	reg  [7:0]     res;
	reg  [7:0]     flags_next;
	reg            wr_res;
	reg            br_wait_reg;
	reg            io_wait_reg;
	reg            io_set_reg;
	reg  [2:0]     io_bit_reg;
	wire           idle = !br_wait_reg && !io_wait_reg;
	wire [PC_W-1:0] offs_ext = {{(PC_W-12){op_offset[11]}}, op_offset};
	wire           f_c = status_flags[`BBX_FLAG_C];
	wire           f_z = status_flags[`BBX_FLAG_Z];
	wire           f_n = status_flags[`BBX_FLAG_N];
	wire           f_v = status_flags[`BBX_FLAG_V];

	always @* begin
		cond = 1'b0;
		is_branch = 1'b1;
		case (op_code)
			`BBX_OP_BR_ZERO0: cond = !f_z;
			`BBX_OP_BR_C0,
			`BBX_OP_BR_UGE:   cond = !f_c;
			`BBX_OP_BR_C1,
			`BBX_OP_BR_ULT:   cond = f_c;
			`BBX_OP_BR_N1:    cond = f_n;
			`BBX_OP_BR_N0:    cond = !f_n;
			`BBX_OP_BR_SGE:   cond = !(f_n ^ f_v);
			`BBX_OP_BR_SLT:   cond = f_n ^ f_v;
			`BBX_OP_BR_H1:    cond = status_flags[`BBX_FLAG_H];
			`BBX_OP_BR_H0:    cond = !status_flags[`BBX_FLAG_H];
			`BBX_OP_BR_T1:    cond = status_flags[`BBX_FLAG_T];
			`BBX_OP_BR_T0:    cond = !status_flags[`BBX_FLAG_T];
			`BBX_OP_BR_V1:    cond = f_v;
			`BBX_OP_BR_V0:    cond = !f_v;
			`BBX_OP_BR_I1:    cond = status_flags[`BBX_FLAG_I];
			`BBX_OP_BR_I0:    cond = !status_flags[`BBX_FLAG_I];
			default:          is_branch = 1'b0;
		endcase
	end

	always @* begin
		res = reg_rdata;
		flags_next = status_flags;
		wr_res = 1'b0;
		case (op_code)
			`BBX_OP_LSL: begin
				res = {reg_rdata[6:0], 1'b0};
				flags_next = shift_flags(status_flags, res, reg_rdata[7]);
				wr_res = 1'b1;
			end
			`BBX_OP_LSR: begin
				res = {1'b0, reg_rdata[7:1]};
				flags_next = shift_flags(status_flags, res, reg_rdata[0]);
				wr_res = 1'b1;
			end
			`BBX_OP_ROL: begin
				res = {reg_rdata[6:0], f_c};
				flags_next = shift_flags(status_flags, res, reg_rdata[7]);
				wr_res = 1'b1;
			end
			`BBX_OP_ROR: begin
				res = {f_c, reg_rdata[7:1]};
				flags_next = shift_flags(status_flags, res, reg_rdata[0]);
				wr_res = 1'b1;
			end
			`BBX_OP_ASR: begin
				res = {reg_rdata[7], reg_rdata[7:1]};
				flags_next = shift_flags(status_flags, res, reg_rdata[0]);
				wr_res = 1'b1;
			end
			`BBX_OP_SWAP: begin
				res = {reg_rdata[3:0], reg_rdata[7:4]};
				wr_res = 1'b1;
			end
			`BBX_OP_BST: begin
				flags_next[`BBX_FLAG_T] = reg_rdata[op_bit];
			end
			`BBX_OP_BLD: begin
				res[op_bit] = status_flags[`BBX_FLAG_T];
				wr_res = 1'b1;
			end
			// one index op covers carry..interrupt, including S and I ops
			`BBX_OP_FLAG_SET: flags_next[op_bit] = 1'b1;
			`BBX_OP_FLAG_CLR: flags_next[op_bit] = 1'b0;
			default: ;
		endcase
	end

	always @(posedge mclk) begin
		if (sys_rst) begin
			status_flags <= `BBX_FLAGS_RESET;
			busy <= 1'b0;
			pc_load <= 1'b0;
			pc_target <= {PC_W{1'b0}};
			reg_we <= 1'b0;
			reg_wdata <= `BBX_ZERO8;
			io_re <= 1'b0;
			io_raddr <= 6'h00;
			io_we <= 1'b0;
			io_waddr <= 6'h00;
			io_wdata <= `BBX_ZERO8;
			br_wait_reg <= 1'b0;
			io_wait_reg <= 1'b0;
			io_set_reg <= 1'b0;
			io_bit_reg <= 3'h0;
		end else begin
			pc_load <= 1'b0;
			reg_we <= 1'b0;
			io_re <= 1'b0;
			io_we <= 1'b0;
			busy <= 1'b0;
			br_wait_reg <= 1'b0;
			if (io_wait_reg) begin
				// second cycle: read-modify-write of one I/O bit
				io_wait_reg <= 1'b0;
				io_we <= 1'b1;
				io_waddr <= io_raddr;
				io_wdata <= io_rdata;
				io_wdata[io_bit_reg] <= io_set_reg;
			end else if (idle && op_valid) begin
				if (is_branch) begin
					if (cond) begin
						// taken: second cycle holds fetch while target loads
						pc_target <= pc_in + offs_ext + `BBX_PC_STEP;
						pc_load <= 1'b1;
						busy <= 1'b1;
						br_wait_reg <= 1'b1;
					end
				end else if (op_code == `BBX_OP_IO_SET || op_code == `BBX_OP_IO_CLR) begin
					io_re <= 1'b1;
					io_raddr <= io_addr;
					io_bit_reg <= op_bit;
					io_set_reg <= (op_code == `BBX_OP_IO_SET);
					io_wait_reg <= 1'b1;
					busy <= 1'b1;
				end else begin
					status_flags <= flags_next;
					reg_we <= wr_res;
					reg_wdata <= res;
				end
			end
		end
	end
endmodule // bbx_exec_unit
`default_nettype wire

// [sim/bbx_exec_assertions.sv]
// checker for the branch, bit and flag execution unit
`include "bbx_exec_map.vh"
`default_nettype none
module bbx_exec_assertions #(parameter PC_W = 16) (
	input wire logic            mclk, sys_rst, op_valid, busy, pc_load, reg_we, io_re, io_we,
	input wire logic [4:0]      op_code,
	input wire logic [2:0]      op_bit,
	input wire logic [11:0]     op_offset,
	input wire logic [PC_W-1:0] pc_in, pc_target,
	input wire logic [7:0]      reg_rdata, io_rdata, reg_wdata, io_wdata, status_flags,
	input wire logic [5:0]      io_addr, io_raddr, io_waddr
);
	// an op offered while busy is dropped, so only idle-cycle offers count
	wire            go  = op_valid & ~busy;
	wire [PC_W-1:0] tgt = pc_in + {{(PC_W-12){op_offset[11]}}, op_offset} + 1'b1;
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	br_target_a: assert property (go && op_code == `BBX_OP_BR_ZERO0 && !status_flags[1]
		|=> pc_load && busy && pc_target == $past(tgt)) else $error("branch target wrong");
	br_skip_a: assert property (go && op_code == `BBX_OP_BR_C1 && !status_flags[0]
		|=> !pc_load && !busy) else $error("carry branch taken on clear carry");
	br_flags_a: assert property (pc_load |-> $stable(status_flags)) else $error("branch changed flags");
	io_seq_a: assert property (go && (op_code == `BBX_OP_IO_SET || op_code == `BBX_OP_IO_CLR)
		|=> io_re && busy && io_raddr == $past(io_addr) ##1 io_we && !busy && $stable(status_flags))
		else $error("io op sequence wrong");
	io_set_a: assert property (io_we && $past(op_code, 2) == `BBX_OP_IO_SET
		|-> io_wdata == ($past(io_rdata) | (8'h01 << $past(op_bit, 2)))) else $error("io set data wrong");
	io_waddr_a: assert property (io_we |-> io_waddr == $past(io_raddr)) else $error("io write address wrong");
	shift_left_a: assert property (go && op_code == `BBX_OP_LSL
		|=> reg_we && reg_wdata == ($past(reg_rdata) << 1) && status_flags[0] == $past(reg_rdata[7]))
		else $error("left shift wrong");
	arith_shift_a: assert property (go && op_code == `BBX_OP_ASR
		|=> reg_wdata == {$past(reg_rdata[7]), $past(reg_rdata[7:1])} && status_flags[0] == $past(reg_rdata[0]))
		else $error("arith shift wrong");
	nibble_swap_a: assert property (go && op_code == `BBX_OP_SWAP
		|=> reg_we && reg_wdata == {$past(reg_rdata[3:0]), $past(reg_rdata[7:4])} && $stable(status_flags))
		else $error("swap wrong");
	cover property (pc_load);
	cover property (io_we);
	cover property (busy && op_valid);
endmodule // bbx_exec_assertions
`default_nettype wire

// [sim/bbx_exec_unit_tb.sv]
// self-checking bench for the execution unit
`include "bbx_exec_map.vh"
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; $display("[FAIL] %0t mismatch %h %h", $time, a, b); end end
module bbx_exec_unit_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk = 0, sys_rst = 1, op_valid = 0;
	logic [4:0]  op_code = 0;
	logic [2:0]  op_bit = 0;
	logic [11:0] op_offset = 0;
	logic [15:0] pc_in = 0;
	logic [7:0]  reg_rdata = 0, io_rdata = 0, fl = 0;
	logic [5:0]  io_addr = 0;
	wire         busy, pc_load, reg_we, io_re, io_we;
	wire [15:0]  pc_target;
	wire [7:0]   reg_wdata, io_wdata, status_flags;
	wire [5:0]   io_raddr, io_waddr;
	int          seed = 67477, fails = 0, comparisons = 0, cyc = 0;
	logic [25:0] q[$];
	logic [25:0] nt;
	bbx_exec_unit #(.PC_W(16)) dut (.*);
	initial forever #2 mclk = ~mclk;
	task automatic run_op(input logic [4:0] c);
		logic [7:0]  r, d, res;
		logic [2:0]  b;
		logic [11:0] k;
		logic [15:0] p;
		logic        t;
		@(posedge mclk);
		{r, d, b, k, p} = {$random(seed), $random(seed)};
		{op_valid, op_code, reg_rdata, io_rdata, op_bit, op_offset, pc_in, io_addr} <= {1'b1, c, r, d, b, k, p, p[5:0]};
		case (c)
		5'h01: t = !fl[1];
		5'h02, 5'h05: t = fl[0];
		5'h03, 5'h04: t = !fl[0];
		5'h08, 5'h09: t = (fl[2] ^ fl[3]) == c[0];
		5'h06, 5'h07: t = fl[2] ^ c[0];
		5'h0A, 5'h0B: t = fl[5] ^ c[0];
		5'h0C, 5'h0D: t = fl[6] ^ c[0];
		5'h0E, 5'h0F: t = fl[3] ^ c[0];
		5'h10, 5'h11: t = fl[7] ^ c[0];
		default: t = 0;
		endcase
		if (t) q.push_back({2'd0, p + {{4{k[11]}}, k} + 16'h0001, fl});
		if (c == `BBX_OP_IO_SET || c == `BBX_OP_IO_CLR) q.push_back({2'd2, 2'b00, p[5:0], c[0] ? d & ~(8'h01 << b) : d | (8'h01 << b), fl});
		res = r;
		case (c)
		`BBX_OP_LSL: {fl[0], res} = {r, 1'b0};
		`BBX_OP_LSR: {res, fl[0]} = {1'b0, r};
		`BBX_OP_ROL: {fl[0], res} = {r, fl[0]};
		`BBX_OP_ROR: {res, fl[0]} = {fl[0], r};
		`BBX_OP_ASR: {res, fl[0]} = {r[7], r};
		`BBX_OP_SWAP: res = {r[3:0], r[7:4]};
		`BBX_OP_BLD: res[b] = fl[6];
		`BBX_OP_BST: fl[6] = r[b];
		`BBX_OP_FLAG_SET: fl[b] = 1'b1;
		`BBX_OP_FLAG_CLR: fl[b] = 1'b0;
		default: ;
		endcase
		if (c >= `BBX_OP_LSL && c <= `BBX_OP_ASR) fl[4:1] = {fl[0], res[7] ^ fl[0], res[7], res == 8'h00};
		if (c >= `BBX_OP_LSL && c <= `BBX_OP_SWAP || c == `BBX_OP_BLD) q.push_back({2'd1, 8'h00, res, fl});
		// offer a swap in the wait cycle: it must be dropped, so no note
		if (t || c == `BBX_OP_IO_SET || c == `BBX_OP_IO_CLR) begin
			@(posedge mclk);
			op_code <= `BBX_OP_SWAP;
		end
	endtask
	always @(posedge mclk) begin
		#1;
		if (pc_load | reg_we | io_we) begin
			if (q.size() == 0) nt = '1;
			else nt = q.pop_front();
			`CHK({pc_load ? 2'd0 : reg_we ? 2'd1 : 2'd2, pc_load ? pc_target : reg_we ? {8'h00, reg_wdata} : {2'b00, io_waddr, io_wdata}, status_flags}, nt)
		end
	end
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fails++;
			stop_test;
		end
	end
	task stop_test;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge mclk);
		sys_rst <= 0;
		for (int i = 0; i < 30; i++) run_op(i[4:0]);
		repeat (600) run_op($unsigned($random(seed)) % 30);
		@(posedge mclk);
		op_valid <= 0;
		repeat (3) @(posedge mclk);
		`CHK(status_flags, fl)
		`CHK(q.size(), 0)
		stop_test;
	end
endmodule // bbx_exec_unit_tb
bind bbx_exec_unit bbx_exec_assertions #(.PC_W(PC_W)) chk (.*);
`default_nettype wire
